// >>> shared/tprs_pkg.sv
// constants and carrier types for the trap pair and repeat sequencer
package tprs_pkg;
   localparam int XW = 18;
   localparam int WW = 36;
   // opcode field and opcodes
   localparam int         OPC_LSB        = 9;
   localparam logic [8:0] OP_PRIV_ENTRY  = 9'h001;
   localparam logic [8:0] OP_DERAIL      = 9'h002;
   localparam logic [8:0] OP_REPEAT      = 9'h150;
   // trap slot offsets from the switch constant
   localparam logic [17:0] SLOT_PRIV      = 18'h0_0004;
   localparam logic [17:0] SLOT_DERAIL    = 18'h0_000c;
   // instruction word fields (word bit 0 is the msb)
   localparam int ADDR_LSB  = 18;
   localparam int LOAD_BIT  = 25;
   localparam int DELTA_W   = 6;
   localparam int TM_LSB    = 4;
   localparam int TD_W      = 3;
   localparam logic [1:0] TM_RI = 2'h1;
   // index zero fields: tally in the top byte, terminate bits at the bottom
   localparam int TALLY_LSB = 10;
   localparam int T_ZERO_ON = 6;
   localparam int T_ZERO_OF = 5;
   localparam int T_NEG_ON  = 4;
   localparam int T_NEG_OF  = 3;
   localparam int T_CRY_ON  = 2;
   localparam int T_CRY_OF  = 1;
   localparam int T_OVF     = 0;
   // register map
   localparam logic [11:0] REG_INDIC  = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_XBASE  = 12'h020;
   localparam int IND_MM  = 0;
   localparam int IND_TRO = 1;

   typedef enum logic [2:0] {
      S_IDLE   = 3'b000,
      S_TRAP1  = 3'b001,
      S_TRAP2  = 3'b010,
      S_RWAIT  = 3'b011,
      S_RISSUE = 3'b100,
      S_RDONE  = 3'b101
   } tprs_state_e;

   typedef struct packed {
      logic          transfer;
      logic [XW-1:0] target;
      logic          transfer_to_slave;
      logic          ret;
      logic          ret_b28;
      logic          zero;
      logic          neg;
      logic          carry;
      logic          ovf;
      logic          ovf_mask;
      logic          fault;
   } tprs_exres_s;

   typedef struct packed {
      logic          valid;
      logic          slot;
      logic          indirect;
      logic [XW-1:0] addr;
      logic [WW-1:0] word;
   } tprs_exreq_s;
endpackage

// >>> rtl/tprs_sequencer.sv
// trap pair and repeat-single sequencer with apb register access
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Contract
// [RULE_01] privileged entry runs slot pair at switch constant plus 4 and 5
// [RULE_02] derail runs slot pair at switch constant plus 12 and 13
// [RULE_03] slot offset comes from the fault switches, not the instruction
// [RULE_04] trap ignores address modification and changes no indicator
// [RULE_05] slot instruction that transfers, other than slave transfer, sets privileged on
// [RULE_06] restore transfer with bit 28 zero or slave transfer sets privileged off
// [RULE_07] privileged during trap and its pair; afterwards follows the indicator
// [RULE_08] program keeps first slot instruction off second word and off execute double
// [RULE_09] transfer by first slot instruction takes effect and skips the second
// [RULE_10] pair without transfer resumes at trap counter plus one
// [RULE_11] repeat runs next instruction until exit, no modifiers, no indicator change
// [RULE_12] load bit set copies instruction bits 0 to 17 into index zero
// [RULE_13] tally and terminate bits of index zero steer loop; tally zero means 256
// [RULE_14] each iteration executes then decrements the tally by one
// [RULE_15] terminate condition clears tally runout and exits, before tally check
// [RULE_16] tally zero without terminate sets tally runout and exits, else loops
// [RULE_17] any fault in the loop ends the loop
// [RULE_18] program puts no forbidden instruction under the repeat
// [RULE_19] repeated instruction uses register or register-indirect with index 1 to 7
// [RULE_20] first pass address is address field plus index, written back
// [RULE_21] later passes address is delta plus index, written back
// [RULE_22] register-indirect makes one indirect fetch per pass, its tag ignored
// [RULE_23] bits 11 to 16 exit on zero, negative, carry on or off
// [RULE_24] bit 17 zero ignores overflow; set exits on masked overflow else traps
// [RULE_25] on exit index zero holds the residue, terminate bits unchanged
module tprs_sequencer
   import tprs_pkg::*;
#(
   parameter int SW_W = 18
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [SW_W-1:0]   fault_switches,
   input  wire logic              in_valid,
   input  wire logic [WW-1:0]     in_word,
   input  wire logic [XW-1:0]     in_ic,
   output logic                   in_ready,
   output tprs_exreq_s            ex_req,
   input  wire logic              ex_done,
   input  wire tprs_exres_s       ex_res,
   output logic                   ovf_ignore,
   output logic                   ic_load,
   output logic [XW-1:0]          ic_next,
   output logic                   privileged,
   output logic                   mm_indicator,
   output logic                   tally_runout
);

   if (SW_W < 1 || SW_W > XW)
   begin
      $error("switch width out of range");
   end

   typedef struct packed {
      tprs_state_e      st;
      logic [7:0][XW-1:0] x;
      logic             mm_ind;
      logic             tro;
      logic             prv;
      logic             busy;
      logic             in_ready;
      logic             ic_load;
      logic [XW-1:0]    ic_next;
      logic [XW-1:0]    trap_ic;
      logic [XW-1:0]    slot1;
      logic [XW-1:0]    rep_ic;
      logic [WW-1:0]    rep_word;
      logic [DELTA_W-1:0] delta;
      logic             first;
      logic             ovf_ign;
      tprs_exreq_s      ex;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
   } tprs_regs_s;

   tprs_regs_s q;
   tprs_regs_s d;

   // indicator after one slot instruction
   function automatic logic mm_next(logic cur, tprs_exres_s r);
      if (r.transfer_to_slave || (r.ret && !r.ret_b28))
         return 1'b0;
      if (r.transfer)
         return 1'b1;
      return cur;
   endfunction

   // exit condition from terminate bits and result flags
   function automatic logic term_hit(logic [XW-1:0] x0, tprs_exres_s r);
      return (x0[T_ZERO_ON] && r.zero) || (x0[T_ZERO_OF] && !r.zero)
          || (x0[T_NEG_ON] && r.neg) || (x0[T_NEG_OF] && !r.neg)
          || (x0[T_CRY_ON] && r.carry) || (x0[T_CRY_OF] && !r.carry)
          || (x0[T_OVF] && r.ovf && r.ovf_mask);
   endfunction

   logic          acc;
   logic          xsel;
   logic [2:0]    xidx;
   logic          hit;
   logic [31:0]   rdv;
   logic [8:0]    opc;
   logic          take;
   logic [XW-1:0] base;
   logic [XW-1:0] ea;
   logic [2:0]    dsg;
   logic [7:0]    tally;

   assign acc  = psel && penable;
   assign xsel = paddr[11:5] == REG_XBASE[11:5];
   assign xidx = paddr[4:2];
   assign hit  = xsel || paddr == REG_INDIC || paddr == REG_STATUS;
   assign opc  = in_word[OPC_LSB +: 9];
   assign take = in_valid && q.in_ready;
   assign dsg  = q.rep_word[TD_W-1:0];
   assign tally = q.x[0][TALLY_LSB +: 8] - 8'h01;

   always_comb
   begin
      rdv = 32'h0000_0000;
      if (xsel)
         rdv = {14'h0000, q.x[xidx]};
      else if (paddr == REG_INDIC)
         rdv = {30'h0000_0000, q.tro, q.mm_ind};
      else if (paddr == REG_STATUS)
         rdv = {27'h0000_000, q.prv, q.busy, q.st};
   end

   always_comb
   begin
      base = SLOT_PRIV;
      ea = q.x[dsg];
      d = q;
      d.ic_load = 1'b0;
      d.ex.valid = 1'b0;
      d.pready = 1'b0;
      // apb: answer one cycle into the access phase
      if (acc && !q.pready)
      begin
         d.pready = 1'b1;
         d.pslverr = !hit || (pwrite && (q.busy || paddr == REG_STATUS));
         d.prdata = pwrite ? 32'h0000_0000 : rdv;
      end
      if (acc && q.pready && pwrite && !q.pslverr)
      begin
         if (xsel)
            d.x[xidx] = pwdata[XW-1:0];
         else
         begin
            d.mm_ind = pwdata[IND_MM];
            d.tro = pwdata[IND_TRO];
         end
      end
      unique case (q.st)
         S_IDLE:
         begin
            if (take && (opc == OP_PRIV_ENTRY || opc == OP_DERAIL))
            begin
               // modification field unused, indicators untouched  see [RULE_04]
               base = (opc == OP_PRIV_ENTRY) ? SLOT_PRIV : SLOT_DERAIL;
               d.st = S_TRAP1;
               d.busy = 1'b1;
               d.trap_ic = in_ic;
               d.ex.valid = 1'b1;
               d.ex.slot = 1'b1;
               d.ex.indirect = 1'b0;
               d.ex.word = '0;
               d.ex.addr = XW'(fault_switches) + base;  // see [RULE_01] see [RULE_02] see [RULE_03]
               d.slot1 = XW'(fault_switches) + base + 18'h0_0001;
            end
            else if (take && opc == OP_REPEAT)
            begin
               if (in_word[LOAD_BIT])
                  d.x[0] = in_word[ADDR_LSB +: XW];  // see [RULE_12]
               d.delta = in_word[DELTA_W-1:0];
               d.st = S_RWAIT;  // see [RULE_11]
               d.busy = 1'b1;
               d.first = 1'b1;
            end
         end
         S_TRAP1:
         begin
            if (ex_done)
            begin
               d.mm_ind = mm_next(q.mm_ind, ex_res);  // see [RULE_05] see [RULE_06]
               if (ex_res.transfer)
               begin
                  d.ic_load = 1'b1;
                  d.ic_next = ex_res.target;  // see [RULE_09]
                  d.st = S_IDLE;
                  d.busy = 1'b0;
               end
               else
               begin
                  d.st = S_TRAP2;
                  d.ex.valid = 1'b1;
                  d.ex.addr = q.slot1;
               end
            end
         end
         S_TRAP2:
         begin
            if (ex_done)
            begin
               d.mm_ind = mm_next(q.mm_ind, ex_res);  // see [RULE_05] see [RULE_06]
               d.ic_load = 1'b1;
               d.ic_next = ex_res.transfer ? ex_res.target : q.trap_ic + 18'h0_0001;  // see [RULE_10]
               d.st = S_IDLE;
               d.busy = 1'b0;
            end
         end
         S_RWAIT:
         begin
            if (take)
            begin
               d.rep_word = in_word;
               d.rep_ic = in_ic;
               d.st = S_RISSUE;
            end
         end
         S_RISSUE:
         begin
            // designator field takes any index 0 to 7; keeping it to 1 to 7 is left to the program  see [RULE_19]
            if (q.first)
               ea = q.rep_word[ADDR_LSB +: XW] + q.x[dsg];  // see [RULE_20]
            else
               ea = XW'(q.delta) + q.x[dsg];  // see [RULE_21]
            d.x[dsg] = ea;
            d.first = 1'b0;
            d.ex.valid = 1'b1;
            d.ex.slot = 1'b0;
            d.ex.addr = ea;
            d.ex.word = q.rep_word;
            d.ex.indirect = q.rep_word[TM_LSB +: 2] == TM_RI;  // see [RULE_22]
            d.st = S_RDONE;
         end
         S_RDONE:
         begin
            if (ex_done && ex_res.fault)
            begin
               d.st = S_IDLE;  // see [RULE_17]
               d.busy = 1'b0;
            end
            else if (ex_done)
            begin
               d.x[0][TALLY_LSB +: 8] = tally;  // see [RULE_14] see [RULE_25]
               if (term_hit(q.x[0], ex_res))
               begin
                  d.tro = 1'b0;  // see [RULE_15] see [RULE_23] see [RULE_24]
                  d.st = S_IDLE;
               end
               else if (tally == 8'h00)
               begin
                  d.tro = 1'b1;  // see [RULE_16] see [RULE_13]
                  d.st = S_IDLE;
               end
               else
                  d.st = S_RISSUE;
               if (d.st == S_IDLE)
               begin
                  d.busy = 1'b0;
                  d.ic_load = 1'b1;
                  d.ic_next = q.rep_ic + 18'h0_0001;
               end
            end
         end
         default:
         begin
            d.st = S_IDLE;
            d.busy = 1'b0;
         end
      endcase
      d.prv = (d.st == S_TRAP1 || d.st == S_TRAP2) ? 1'b1 : d.mm_ind;  // see [RULE_07]
      d.in_ready = d.st == S_IDLE || d.st == S_RWAIT;
      d.ovf_ign = (d.st == S_RISSUE || d.st == S_RDONE) && !d.x[0][T_OVF];  // see [RULE_24]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         q.in_ready <= 1'b1;
      end
      else
         q <= d;
   end

   assign prdata       = q.prdata;
   assign pready       = q.pready;
   assign pslverr      = q.pslverr;
   assign in_ready     = q.in_ready;
   assign ex_req       = q.ex;
   assign ovf_ignore   = q.ovf_ign;
   assign ic_load      = q.ic_load;
   assign ic_next      = q.ic_next;
   assign privileged   = q.prv;
   assign mm_indicator = q.mm_ind;
   assign tally_runout = q.tro;

   a_priv_slot_addr: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_01]
      q.st == S_IDLE && take && opc == OP_PRIV_ENTRY |=> ex_req.valid && ex_req.slot
         && ex_req.addr == XW'($past(fault_switches)) + 18'h0_0004)
      else $error("privileged entry slot address wrong");
   a_derail_slot_addr: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_02]
      q.st == S_IDLE && take && opc == OP_DERAIL |=> ex_req.valid
         && ex_req.addr == XW'($past(fault_switches)) + 18'h0_000c)
      else $error("derail slot address wrong");
   a_trap_forces_priv: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_07]
      (q.st == S_TRAP1 || q.st == S_TRAP2) |-> privileged)
      else $error("trap pair not privileged");
   a_slave_clears_mm: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_06]
      (q.st == S_TRAP1 || q.st == S_TRAP2) && ex_done && ex_res.transfer_to_slave |=> !mm_indicator)
      else $error("slave transfer left indicator on");
   a_xfer_sets_mm: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_05]
      (q.st == S_TRAP1 || q.st == S_TRAP2) && ex_done && ex_res.transfer && !ex_res.transfer_to_slave
         && !(ex_res.ret && !ex_res.ret_b28) |=> mm_indicator)
      else $error("slot transfer did not set indicator");
   a_first_xfer_skip: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_09]
      q.st == S_TRAP1 && ex_done && ex_res.transfer |=> ic_load && !ex_req.valid
         && ic_next == $past(ex_res.target) ##1 q.st == S_IDLE && !ex_req.valid)
      else $error("second slot not skipped");
   a_pair_resume: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_10]
      q.st == S_TRAP2 && ex_done && !ex_res.transfer |=> ic_load
         && ic_next == $past(q.trap_ic) + 18'h0_0001)
      else $error("wrong resume after pair");
   a_fault_ends_loop: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_17]
      q.st == S_RDONE && ex_done && ex_res.fault |=> q.st == S_IDLE && !ic_load)
      else $error("fault did not end loop");
   a_term_clears_tro: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_15]
      q.st == S_RDONE && ex_done && !ex_res.fault && term_hit(q.x[0], ex_res)
         |=> !tally_runout && q.st == S_IDLE)
      else $error("terminate exit wrong");
   a_tally_load: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_12]
      q.st == S_IDLE && take && opc == OP_REPEAT && in_word[LOAD_BIT]
         |=> q.x[0] == $past(in_word[ADDR_LSB +: XW]))
      else $error("index zero not loaded");
   a_tally_step: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_14]
      q.st == S_RDONE && ex_done && !ex_res.fault
         |=> q.x[0][TALLY_LSB +: 8] == $past(q.x[0][TALLY_LSB +: 8]) - 8'h01
         && q.x[0][6:0] == $past(q.x[0][6:0]))
      else $error("tally step wrong");
   a_runout_sets_tro: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_16]
      q.st == S_RDONE && ex_done && !ex_res.fault && !term_hit(q.x[0], ex_res)
         && tally == 8'h00 |=> tally_runout && ic_load && q.st == S_IDLE)
      else $error("tally runout exit wrong");
   a_loop_again: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_16]
      q.st == S_RDONE && ex_done && !ex_res.fault && !term_hit(q.x[0], ex_res)
         && tally != 8'h00 |=> q.st == S_RISSUE && !ic_load)
      else $error("loop did not continue");
   a_ea_written_back: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_20]
      q.st == S_RISSUE |=> ex_req.valid && !ex_req.slot && ex_req.addr == q.x[$past(dsg)])
      else $error("address not written back");
   a_repeat_no_ind: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_11]
      q.st == S_IDLE && take && opc == OP_REPEAT && !pready |=> tally_runout == $past(tally_runout)
         && mm_indicator == $past(mm_indicator))
      else $error("repeat changed an indicator");
   a_trap_keeps_tro: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_04]
      q.st == S_IDLE && take && (opc == OP_PRIV_ENTRY || opc == OP_DERAIL) && !pready
         |=> tally_runout == $past(tally_runout))
      else $error("trap changed an indicator");
   a_ovf_ignore_lvl: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE_24]
      ex_req.valid && !ex_req.slot |-> ovf_ignore == !q.x[0][T_OVF])
      else $error("overflow ignore wrong");
endmodule

// >>> verification/tprs_exec_model.sv
// behavioural execution unit and memory facing the sequencer
`timescale 1ns/1ps
module tprs_exec_model
   import tprs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire tprs_exreq_s ex_req,
   output logic             ex_done,
   output tprs_exres_s      ex_res
);
   tprs_exres_s pend[$];
   tprs_exres_s cur;
   int          lat = 1;
   int          cnt;
   logic        busy;

   task push(input tprs_exres_s r);
      pend.push_back(r);
   endtask

   // one request at a time; result only valid with done, garbage otherwise
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ex_done <= 1'b0;
         ex_res <= '1;
         busy <= 1'b0;
      end
      else
      begin
         ex_done <= 1'b0;
         ex_res <= ~ex_res;
         if (ex_req.valid)
         begin
            busy <= 1'b1;
            cnt <= lat;
            cur <= (pend.size() > 0) ? pend.pop_front() : '0;
         end
         else if (busy && cnt <= 1)
         begin
            ex_done <= 1'b1;
            ex_res <= cur;
            busy <= 1'b0;
         end
         else if (busy)
            cnt <= cnt - 1;
      end
   end
endmodule

// >>> verification/tprs_sequencer_test.sv
// self-checking bench for the trap pair and repeat sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tprs_sequencer_test
   import tprs_pkg::*;
;
   localparam logic [17:0] C = 18'h0_0100;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, in_ready, ex_done, ovf_ignore, ic_load;
   logic        privileged, mm_indicator, tally_runout, in_valid = 0;
   logic [17:0] fault_switches = C, in_ic = '0, ic_next, last_ic;
   logic [35:0] in_word = '0;
   tprs_exreq_s ex_req;
   tprs_exres_s ex_res;
   tprs_exreq_s rq[$];
   logic [1:0]  fq[$];
   int          bad_count = 0, checked = 0, nload = 0;

   always #2.5 pclk = ~pclk;

   tprs_sequencer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .fault_switches, .in_valid, .in_word, .in_ic,
      .in_ready, .ex_req, .ex_done, .ex_res, .ovf_ignore, .ic_load, .ic_next,
      .privileged, .mm_indicator, .tally_runout);
   tprs_exec_model u_mem (.pclk, .presetn, .ex_req, .ex_done, .ex_res);

   // log requests and counter loads as the design presents them
   always @(posedge pclk)
   begin
      if (ex_req.valid === 1'b1)
      begin
         rq.push_back(ex_req);
         fq.push_back({privileged, ovf_ignore});
      end
      if (ic_load === 1'b1)
      begin
         nload++;
         last_ic = ic_next;
      end
   end

   task summarize;
      if (bad_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin bad_count++; summarize; end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task send(input logic [35:0] w, input logic [17:0] ic);
      int n;
      @(posedge pclk);
      in_valid <= 1'b1;
      in_word <= w;
      in_ic <= ic;
      for (n = 0; n < 50; n++)
      begin
         @(posedge pclk);
         if (in_ready === 1'b1) break;
      end
      if (n == 50) begin bad_count++; summarize; end
      in_valid <= 1'b0;
      in_word <= ~w;
   endtask

   task settle;
      int n;
      for (n = 0; n < 3000; n++)
      begin
         @(posedge pclk);
         #1;
         if (in_ready === 1'b1) break;
      end
      if (n == 3000) begin bad_count++; summarize; end
      @(posedge pclk);
      #1;
   endtask

   task t_regs;
      logic [31:0] d;
      logic e;
      `CHK("idle ready", 1'b1, in_ready)
      apb(0, REG_INDIC, 32'h0000_0000, d, e);
      `CHK("indic reset", 32'h0000_0000, d)
      apb(1, REG_XBASE + 12'h00c, 32'hffff_abcd, d, e);
      apb(0, REG_XBASE + 12'h00c, 32'h0000_0000, d, e);
      `CHK("x3 back", 32'h0003_abcd, d)
      apb(0, 12'h100, 32'h0000_0000, d, e);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0000_0000, d)
      apb(1, REG_STATUS, 32'h0000_001f, d, e);
      `CHK("status ro", 1'b1, e)
      apb(1, REG_INDIC, 32'h0000_0001, d, e);
      #1;
      `CHK("priv follows", 1'b1, privileged)
      apb(1, REG_INDIC, 32'h0000_0000, d, e);
      send({18'h0_0000, 9'h075, 9'h000}, 18'h0_0010);
      repeat (4) @(posedge pclk);
      `CHK("other op", 0, rq.size())
   endtask

   task trap(input logic [8:0] op, input tprs_exres_s r1, input tprs_exres_s r2,
             input int n, input logic [17:0] ic_e, input logic mm_e);
      int i;
      int l0;
      logic [17:0] sa;
      rq.delete();
      fq.delete();
      u_mem.pend.delete();
      l0 = nload;
      sa = C + (op == OP_DERAIL ? 18'h0_000c : 18'h0_0004);
      u_mem.push(r1);
      u_mem.push(r2);
      send({18'h3_ffff, op, 3'b111, 6'h3f}, 18'h0_0040);
      settle;
      `CHK("trap reqs", n, rq.size())
      for (i = 0; i < rq.size(); i++)
      begin
         `CHK("slot addr", sa + 18'(i), rq[i].addr)
         `CHK("slot kind", 1'b1, rq[i].slot)
         `CHK("priv in pair", 1'b1, fq[i][1])
      end
      `CHK("trap load", l0 + 1, nload)
      `CHK("trap next", ic_e, last_ic)
      `CHK("mm ind", mm_e, mm_indicator)
      `CHK("priv after", mm_e, privileged)
   endtask

   task repeat_single(input logic [7:0] t, input logic [6:0] term, input logic [5:0] tag,
            input tprs_exres_s r, input int n, input logic ld, input logic ro);
      logic [31:0] d, x0e;
      logic e;
      int i;
      int l0;
      apb(1, REG_XBASE + {7'h00, tag[2:0], 2'b00}, 32'h0000_0010, d, e);
      rq.delete();
      fq.delete();
      u_mem.pend.delete();
      l0 = nload;
      for (i = 0; i < n; i++)
         u_mem.push(i == n - 1 ? r : '0);
      send({t, 2'b00, 1'b1, term, OP_REPEAT, 3'b000, 6'h02}, 18'h0_0080);
      send({18'h0_0100, 9'h075, 3'b000, tag}, 18'h0_0081);
      settle;
      `CHK("rpt reqs", n, rq.size())
      for (i = 0; i < rq.size(); i++)
      begin
         `CHK("rpt addr", 18'h0_0110 + 18'(2 * i), rq[i].addr)
         `CHK("rpt word", {18'h0_0100, 9'h075, 3'b000, tag}, rq[i].word)
         `CHK("indirect", tag[4], rq[i].indirect)
         `CHK("ovf ignore", ~term[0], fq[i][0])
      end
      `CHK("rpt load", l0 + int'(ld), nload)
      x0e = {14'h0000, t - 8'(n), 2'b00, 1'b1, term};
      if (ld)
      begin
         `CHK("rpt next", 18'h0_0082, last_ic)
         `CHK("runout", ro, tally_runout)
         apb(0, REG_XBASE, 32'h0000_0000, d, e);
         `CHK("x0 residue", x0e, d)
      end
   endtask

   task t_trap;
      tprs_exres_s xf, ts, rt;
      xf = '{transfer: 1'b1, target: 18'h0_3000, default: '0};
      ts = '{transfer: 1'b1, transfer_to_slave: 1'b1, target: 18'h0_3100, default: '0};
      rt = '{transfer: 1'b1, ret: 1'b1, target: 18'h0_3200, default: '0};
      trap(OP_PRIV_ENTRY, '0, '0, 2, 18'h0_0041, 1'b0);
      trap(OP_DERAIL, xf, '0, 1, 18'h0_3000, 1'b1);
      trap(OP_PRIV_ENTRY, '0, rt, 2, 18'h0_3200, 1'b0);
      trap(OP_PRIV_ENTRY, '0, xf, 2, 18'h0_3000, 1'b1);
      trap(OP_DERAIL, ts, '0, 1, 18'h0_3100, 1'b0);
   endtask

   task t_rpt;
      tprs_exres_s r;
      int k;
      repeat_single(8'h03, 7'h00, 6'h01, '0, 3, 1'b1, 1'b1);
      repeat_single(8'h02, 7'h01, 6'h12, '0, 2, 1'b1, 1'b1);
      repeat_single(8'h00, 7'h60, 6'h03, '0, 1, 1'b1, 1'b0);
      repeat_single(8'h00, 7'h00, 6'h06, '0, 256, 1'b1, 1'b1);
      r = '{ovf: 1'b1, ovf_mask: 1'b1, default: '0};
      repeat_single(8'h05, 7'h01, 6'h01, r, 1, 1'b1, 1'b0);
      repeat_single(8'h01, 7'h00, 6'h01, r, 1, 1'b1, 1'b1);
      for (k = 1; k < 7; k++)
      begin
         r = '{zero: k == 6, neg: k == 4, carry: k == 2, default: '0};
         repeat_single(8'h05, 7'(1 << k), 6'h05, r, 1, 1'b1, 1'b0);
      end
      u_mem.lat = 6;
      repeat_single(8'h04, 7'h00, 6'h04, '{fault: 1'b1, default: '0}, 1, 1'b0, 1'b0);
      u_mem.lat = 1;
   endtask

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_trap;
      t_rpt;
      summarize;
   end
endmodule
